// file: ecr_consts.vh
/*
  Constants for the endpoint capability register bank: register byte
  addresses, field positions and the fixed values each field returns.
  Assumes inclusion by bare name from the design files only.
*/
`ifndef ECR_CONSTS_VH
`define ECR_CONSTS_VH

// Register byte addresses on the AHB-Lite bus
`define ECR_ASSEMBLY_INFO_ADDR 32'h0000100c
`define ECR_FEATURES_ADDR 32'h00001010

// Assembly information fields
`define ECR_ASSEMBLY_REV_LSB 16
`define ECR_ASSEMBLY_REV_VAL 16'h0000
`define ECR_LIST_PTR_LSB 0
`define ECR_LIST_PTR_VAL 16'h0100

// Features register bit positions
`define ECR_BRIDGE_BIT 31
`define ECR_MEMORY_BIT 30
`define ECR_PROCESSOR_BIT 29
`define ECR_SWITCH_BIT 28
`define ECR_VARIANT_LSB 8
`define ECR_FLOW_CTRL_BIT 7
`define ECR_CRC_SKIP_BIT 6
`define ECR_CRF_BIT 5
`define ECR_LARGE_BIT 4
`define ECR_EXT_FEAT_BIT 3
`define ECR_ADDR_CAP_LSB 0

// Features register fixed field values
`define ECR_BRIDGE_VAL 1'b0
`define ECR_MEMORY_VAL 1'b0
`define ECR_PROCESSOR_VAL 1'b1
`define ECR_SWITCH_VAL 1'b0
`define ECR_VARIANT_ZERO 8'h00
`define ECR_VARIANT_ONE 8'h01
`define ECR_FLOW_CTRL_VAL 1'b0
`define ECR_CRC_SKIP_VAL 1'b0
`define ECR_CRF_VAL 1'b0
`define ECR_LARGE_VAL 1'b0
`define ECR_EXT_FEAT_VAL 1'b1
`define ECR_ADDR_CAP_VAL 3'b001

// Cycles after reset release before the strap is sampled
`define ECR_STRAP_SETTLE 2'h3
`define ECR_DATA_RESET 32'h00000000

`endif

// file: ecr_strap_sync.v
/*
  Three-stage synchroniser for the asynchronous variant strap pin.
  Assumes one clock, hclk, and an active-low asynchronous reset.
  Exposes the second and third stages so the caller can check agreement.
*/
`timescale 1ns/10ps
module ecr_strap_sync (
  hclk,
  hresetn,
  strap_in,
  sync_mid,
  sync_out
);
  input wire hclk;
  input wire hresetn;
  input wire strap_in;
  output wire sync_mid;
  output wire sync_out;

  reg [2:0] stage_r;

  // Stage 0 feeds only stage 1; nothing else may look at it
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage_r <= 3'h0;
    end else begin
      stage_r <= {stage_r[1:0], strap_in};
    end
  end

  assign sync_mid = stage_r[1];
  assign sync_out = stage_r[2];
endmodule

// file: ecr_capability_regs.v
/*
  Endpoint capability register bank: assembly information and element
  features, both read-only, as an AHB-Lite slave with zero wait states.
  Assumes a single AHB-Lite master, word transfers, and a variant strap
  pin that is stable from reset release onward.
*/
`timescale 1ns/10ps
`include "ecr_consts.vh"
module ecr_capability_regs (
  hclk,
  hresetn,
  hsel,
  haddr,
  htrans,
  hwrite,
  hsize,
  hwdata,
  hready,
  hreadyout,
  hresp,
  hrdata,
  variant_strap
);
  input wire hclk;
  input wire hresetn;
  input wire hsel;
  input wire [31:0] haddr;
  input wire [1:0] htrans;
  input wire hwrite;
  input wire [2:0] hsize;
  input wire [31:0] hwdata;
  input wire hready;
  output wire hreadyout;
  output wire hresp;
  output wire [31:0] hrdata;
  input wire variant_strap;

  localparam ST_SETTLE = 2'b01;
  localparam ST_LOCKED = 2'b10;

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [1:0] settle_cnt_r;
  reg [7:0] variant_r;
  reg [31:0] hrdata_r;
  wire strap_mid;
  wire strap_out;
  wire access;
  wire [31:0] assembly_word;
  wire [31:0] features_word;

  ecr_strap_sync ecr_strap_sync_inst (
    .hclk(hclk),
    .hresetn(hresetn),
    .strap_in(variant_strap),
    .sync_mid(strap_mid),
    .sync_out(strap_out)
  );

  // Strap is taken once, when two synchronised stages agree, then locked
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_SETTLE: begin
        if (settle_cnt_r == `ECR_STRAP_SETTLE && strap_mid == strap_out) begin
          state_nxt = ST_LOCKED;
        end
      end
      ST_LOCKED: begin
        state_nxt = ST_LOCKED;
      end
      default: begin
        state_nxt = ST_SETTLE;
      end
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= ST_SETTLE;
      settle_cnt_r <= 2'h0;
      variant_r <= `ECR_VARIANT_ZERO;
    end else begin
      state_r <= state_nxt;
      if (settle_cnt_r != `ECR_STRAP_SETTLE) begin
        settle_cnt_r <= settle_cnt_r + 2'h1;
      end
      if (state_r == ST_SETTLE && state_nxt == ST_LOCKED) begin
        // Variant field is 00h or 01h only
        variant_r <= strap_out ? `ECR_VARIANT_ONE : `ECR_VARIANT_ZERO;
      end
    end
  end

  assign assembly_word = {`ECR_ASSEMBLY_REV_VAL,
                          `ECR_LIST_PTR_VAL};

  // Reserved 27-16 tie to zero; 15-8 follow the variant
  assign features_word = {`ECR_BRIDGE_VAL,
                          `ECR_MEMORY_VAL,
                          `ECR_PROCESSOR_VAL,
                          `ECR_SWITCH_VAL,
                          12'h000,
                          variant_r,
                          `ECR_FLOW_CTRL_VAL,
                          `ECR_CRC_SKIP_VAL,
                          `ECR_CRF_VAL,
                          `ECR_LARGE_VAL,
                          `ECR_EXT_FEAT_VAL,
                          `ECR_ADDR_CAP_VAL};

  // Unmapped addresses read as zero rather than erroring
  function [31:0] read_mux;
    input [31:0] addr;
    input [31:0] asm_w;
    input [31:0] feat_w;
    begin
      case (addr)
        `ECR_ASSEMBLY_INFO_ADDR: read_mux = asm_w;
        `ECR_FEATURES_ADDR: read_mux = feat_w;
        default: read_mux = 32'h00000000;
      endcase
    end
  endfunction

  assign access = hsel & htrans[1] & hready;

  // Writes are accepted with OKAY but never reach any storage
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= `ECR_DATA_RESET;
    end else if (access && !hwrite) begin
      hrdata_r <= read_mux({haddr[31:2], 2'b00}, assembly_word,
                           features_word);
    end
  end

  // Zero wait states: every data phase completes in one cycle
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;
endmodule

// file: ecr_chk.sv
/* Checker for the capability register bank.
   Sees only the bank's ports; bound to it below. */
`timescale 1ns/10ps
module ecr_chk(
  input wire hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp,
  input wire [1:0] htrans,
  input wire [31:0] haddr, hrdata
);
  wire rd = hsel && htrans[1] && hready && !hwrite;
  wire fr = rd && haddr == 32'h00001010;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  asm_word_a: assert property (
    rd && haddr == 32'h0000100c |=> hrdata == 32'h00000100)
    else $error("bad assembly word");
  proc_bit_a: assert property (fr |=> hrdata[29])
    else $error("processor bit low");
  bridge_bit_a: assert property (fr |=> !hrdata[31])
    else $error("bridge bit high");
  switch_bit_a: assert property (fr |=> !hrdata[28])
    else $error("switch bit high");
  low_bits_a: assert property (
    fr |=> hrdata[7:0] == 8'h09) else $error("bad low bits");
  reserved_a: assert property (
    fr |=> hrdata[27:16] == 12'h000 && hrdata[15:9] == 7'h00)
    else $error("reserved bits set");
  hold_data_a: assert property (!rd |=> $stable(hrdata))
    else $error("read data moved");
  okay_resp_a: assert property (hreadyout && !hresp)
    else $error("not ready or not OKAY");
endmodule
bind ecr_capability_regs ecr_chk ecr_chk_inst(.*);

// file: tb.sv
/* Bench for the capability register bank: AHB-Lite master tasks,
   a queue of expected reads and a monitor. Drives every port. */
`timescale 1ns/10ps
module tb;
  reg hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  reg dp = 1'b0, variant_strap = 1'b0;
  reg [1:0] htrans = 2'h0;
  reg [2:0] hsize = 3'h2;
  reg [31:0] haddr = 32'h0, hwdata = 32'h0, fv;
  reg [15:0] r = 16'h5ab1;
  reg [31:0] q[$];
  wire hreadyout, hresp;
  wire hready = hreadyout;
  wire [31:0] hrdata;
  integer errors = 0, checks = 0, i, k;
  ecr_capability_regs ecr_capability_regs_inst(.*);
  always #50 hclk = ~hclk;
  function [15:0] lf(input [15:0] s);
    lf = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task chk(input [31:0] s, e);
    begin
      checks = checks + 1;
      if (s !== e) begin
        errors = errors + 1;
        $display("[FAIL] hrdata exp %h seen %h", e, s);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  task wt;
    integer n;
    begin
      n = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1) begin
        n = n + 1;
        if (n > 20) begin
          errors = errors + 1;
          print_verdict;
        end
        @(posedge hclk);
      end
    end
  endtask
  // For a read, d is the word expected back
  task xf(input [31:0] a, input w, input [31:0] d);
    begin
      if (!w) q.push_back(d);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      wt;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wt;
    end
  endtask
  always @(posedge hclk) begin
    if (dp) chk(hrdata, q.pop_front());
    dp <= hsel && htrans[1] && !hwrite && hreadyout;
  end
  initial begin
    for (k = 0; k < 2; k = k + 1) begin
      hresetn <= 1'b0;
      variant_strap <= k[0];
      fv = k ? 32'h20000109 : 32'h20000009;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (8) @(posedge hclk);
      for (i = 0; i < 6; i = i + 1) begin
        r = lf(r);
        xf(i[0] ? 32'h00001010 : 32'h0000100c, 1'b1, {r, r});
        xf(32'h0000100c, 1'b0, 32'h00000100);
        xf(32'h00001010, 1'b0, fv);
        xf({r, 16'h0000}, 1'b0, 32'h00000000);
      end
    end
    repeat (2) @(posedge hclk);
    print_verdict;
  end
endmodule
